/* design/tcsr_regs.sv */
// Tile control, boot status, security and oscillator registers
`timescale 1ns/1ps
`include "tcsr_defines.svh"

module tcsr_regs
  import tcsr_pkg::*;
#(
  parameter int DLY_DEPTH = 256,
  parameter int CNT_W     = 16
) (
  input  wire logic            clock_i,
  input  wire logic            resetn_i,
  input  wire tcsr_ps_req_type ps_req_i,
  output tcsr_ps_rsp_type      ps_rsp_o,
  input  wire tcsr_boot_type   boot_pins_i,
  input  wire logic            otp_sec_valid_i,
  input  wire logic [31:0]     otp_sec_word_i,
  input  wire logic            all_paused_i,
  input  wire tcsr_tx_type     tx_beat_i,
  output tcsr_tx_type          tx_beat_o,
  output logic                 tx_clk_o,
  output logic                 rgmii_port_en_o,
  output logic                 clk_div_active_o,
  output logic                 usb_utmi_sel_o,
  output logic                 ulpi_assist_en_o,
  output logic                 jtag_tap_block_o,
  output logic                 global_debug_block_o,
  output logic                 cfg_jtag_block_o,
  output logic                 boot_from_otp_o,
  output logic                 otp_redundancy_en_o,
  output logic                 otp_lock_all_o,
  output logic [3:0]           otp_sector_lock_o,
  input  wire logic [3:0]      osc_tick_i,
  output logic                 osc_core_run_o,
  output logic                 osc_periph_run_o
);

  // Split a resource identifier into a hit flag and register number.
  // Any other low byte belongs to another resource kind, so it is
  // refused rather than aliased onto these registers.
  function automatic logic [8:0] ps_decode(input logic [15:0] res);
    ps_decode = {res[7:0] == `TCSR_PS_LOW, res[15:8]};
  endfunction

  // Keep unwritable bits of a register, update the rest
  // Reserved bits never leave zero, so reads of them stay zero too
  function automatic logic [31:0] masked_write(input logic [31:0] old,
                                               input logic [31:0] val,
                                               input logic [31:0] mask);
    masked_write = (old & ~mask) | (val & mask);
  endfunction

  // Register state
  logic [31:0]      feat;
  logic [31:0]      sec;
  logic [31:0]      osc;
  logic             sec_loaded;
  tcsr_boot_type    boot_s1;
  tcsr_boot_type    boot_s2;
  logic [31:0]      boot_word;

  // Request decode and read path
  logic [8:0]       dec;
  logic             hit;
  logic [7:0]       num;
  logic             wr_feat;
  logic             wr_sec;
  logic             wr_osc;
  logic             wr_bad;
  logic [31:0]      next_rdata;
  logic             next_err;

  // Transmit clock and delay line
  logic [8:0]       div_val;
  logic [8:0]       div_cnt;
  logic [7:0]       dly_val;
  logic [7:0]       wr_ptr;
  tcsr_tx_type      dly_mem [DLY_DEPTH];

  // Oscillator sampling and counts
  logic [3:0]       tick_s1;
  logic [3:0]       tick_s2;
  logic [3:0]       tick_s3;
  logic [3:0]       osc_en;
  // Power-up value only; a system reset leaves the counts alone
  logic [CNT_W-1:0] osc_cnt [4] = '{default: '0};

  // Request decode; 0x0B low byte marks the status space
  assign dec     = ps_decode(ps_req_i.resource);
  assign hit     = dec[8];
  assign num     = dec[7:0];
  assign wr_feat = ps_req_i.wr && hit && (num == `TCSR_REG_FEAT);
  assign wr_sec  = ps_req_i.wr && hit && (num == `TCSR_REG_SEC)
                   && !sec[`TCSR_SEC_LOCK];
  assign wr_osc  = ps_req_i.wr && hit && (num == `TCSR_REG_OSC);
  // Any other write is dropped and flagged
  assign wr_bad  = ps_req_i.wr && !(wr_feat || wr_sec || wr_osc);

  // Feature control register, only documented bits writable
  // Divider field is kept as ratio minus one; no adjustment here
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      feat <= `TCSR_FEAT_RST;
    end else if (wr_feat) begin
      feat <= masked_write(feat, ps_req_i.wdata, `TCSR_FEAT_MASK);
    end
  end

  // Security register: writes until locked; the first OTP copy overwrites it
  // The OTP copy wins over a write in the same cycle, and software
  // writes made before it hold only until the stored security word lands
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      sec        <= `TCSR_SEC_RST;
      sec_loaded <= 1'b0;
    end else if (otp_sec_valid_i && !sec_loaded) begin
      sec        <= otp_sec_word_i & `TCSR_SEC_MASK;
      sec_loaded <= 1'b1;
    end else if (wr_sec) begin
      sec <= masked_write(sec, ps_req_i.wdata, `TCSR_SEC_MASK);
    end
  end

  // Oscillator run control, both enables reset to stopped
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      osc <= `TCSR_OSC_RST;
    end else if (wr_osc) begin
      osc <= masked_write(osc, ps_req_i.wdata, `TCSR_OSC_MASK);
    end
  end

  // Boot straps come from pins, so pass two flip-flops first
  // Straps are levels settled long before boot, so two flops suffice
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      boot_s1 <= '0;
      boot_s2 <= '0;
    end else begin
      boot_s1 <= boot_pins_i;
      boot_s2 <= boot_s1;
    end
  end

  // Boot status word; no write path exists at all
  always_comb begin
    boot_word = 32'h0000_0000;
    boot_word[`TCSR_BOOT_PROC_LSB +: 8] = boot_s2.proc_num;
    boot_word[`TCSR_BOOT_OVR]    = boot_s2.mode_ovr;
    boot_word[`TCSR_BOOT_CORE1]  = boot_s2.core1_off;
    boot_word[`TCSR_BOOT_NOPOLL] = boot_s2.no_otp_poll;
    boot_word[`TCSR_BOOT_RAM]    = boot_s2.boot_ram;
    boot_word[`TCSR_BOOT_JTAG]   = boot_s2.boot_jtag;
    boot_word[`TCSR_BOOT_PLL_LSB +: 2] = boot_s2.pll_mode;
  end

  // Read mux; unmapped numbers read zero and flag an error
  // Counter reads only make sense once the oscillators are stopped
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_err   = wr_bad;
    if (ps_req_i.rd) begin
      if (!hit) begin
        next_err = 1'b1;
      end else begin
        case (num)
          `TCSR_REG_FEAT: next_rdata = feat;
          `TCSR_REG_BOOT: next_rdata = boot_word;
          `TCSR_REG_SEC:  next_rdata = sec;
          `TCSR_REG_OSC:  next_rdata = osc;
          default: begin
            if (num >= `TCSR_REG_CNT0 && num <= `TCSR_REG_CNT3) begin
              next_rdata = {{(32-CNT_W){1'b0}},
                            osc_cnt[2'(num - `TCSR_REG_CNT0)]};
            end else begin
              next_err = 1'b1;
            end
          end
        endcase
      end
    end
  end

  // Answer one cycle after each request
  // Registered so the read mux never sits in the request path
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      ps_rsp_o <= '0;
    end else begin
      ps_rsp_o.ack   <= ps_req_i.rd || ps_req_i.wr;
      ps_rsp_o.err   <= next_err;
      ps_rsp_o.rdata <= next_rdata;
    end
  end

  // Field views of the feature register
  // Fields are read live, so a rewrite retimes the clock at once
  assign div_val = feat[`TCSR_FEAT_DIV_MSB:`TCSR_FEAT_DIV_LSB];
  assign dly_val = feat[`TCSR_FEAT_DLY_MSB:`TCSR_FEAT_DLY_LSB];

  // Transmit clock counter wraps after reaching the divider value
  // A divider of zero parks the count at zero and holds the clock high
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      div_cnt <= 9'h000;
    end else if (div_cnt >= div_val) begin
      div_cnt <= 9'h000;
    end else begin
      div_cnt <= div_cnt + 9'h001;
    end
  end

  // Rise at the divider value, fall at half of it; rise wins a tie
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      tx_clk_o <= 1'b0;
    end else if (!feat[`TCSR_FEAT_RGMII]) begin
      tx_clk_o <= 1'b0;
    end else if (div_cnt == div_val) begin
      tx_clk_o <= 1'b1;
    end else if (div_cnt == (div_val >> 1)) begin
      tx_clk_o <= 1'b0;
    end
  end

  // Delay line write side; memory needs no reset
  // Depth covers every value of the eight-bit delay field
  always_ff @(posedge clock_i) begin
    dly_mem[wr_ptr] <= tx_beat_i;
  end

  // Write pointer runs freely so any delay is available at once
  // Pointer width matches the delay field; a deeper line needs both
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      wr_ptr <= 8'h00;
    end else begin
      wr_ptr <= wr_ptr + 8'h01;
    end
  end

  // Delayed beat; a fixed output stage adds one cycle to every delay
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      tx_beat_o <= '0;
    end else if (!feat[`TCSR_FEAT_RGMII]) begin
      tx_beat_o <= '0;
    end else if (dly_val == 8'h00) begin
      tx_beat_o <= tx_beat_i;
    end else begin
      tx_beat_o <= dly_mem[wr_ptr - dly_val];
    end
  end

  // Feature outputs straight from register bits
  // Mode selects are static settings, so no retiming is needed
  assign rgmii_port_en_o  = feat[`TCSR_FEAT_RGMII];
  assign usb_utmi_sel_o   = feat[`TCSR_FEAT_UTMI];
  assign ulpi_assist_en_o = feat[`TCSR_FEAT_ULPI];

  // Divider gate; pause flag is same-clock core logic, so no sync
  // Registered so pause flag glitches never reach the divider
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      clk_div_active_o <= 1'b0;
    end else begin
      clk_div_active_o <= feat[`TCSR_FEAT_DIVEN]
                          && (!feat[`TCSR_FEAT_DYN] || all_paused_i);
    end
  end

  // Security outputs straight from register bits
  // Consumers share this clock, so the flags need no retiming
  assign jtag_tap_block_o     = sec[`TCSR_SEC_TAP];
  assign global_debug_block_o = sec[`TCSR_SEC_GDBG];
  assign cfg_jtag_block_o     = sec[`TCSR_SEC_CFGJTAG];
  assign boot_from_otp_o      = sec[`TCSR_SEC_OTPBOOT];
  assign otp_redundancy_en_o  = sec[`TCSR_SEC_RED];
  assign otp_lock_all_o       = sec[`TCSR_SEC_OTPALL];
  // All-sector lock folds into every sector lock
  assign otp_sector_lock_o = sec[`TCSR_SEC_SECT_MSB:`TCSR_SEC_SECT_LSB]
                             | {4{sec[`TCSR_SEC_OTPALL]}};

  // Run enables leave the block to the oscillators themselves
  // Stopping acts at the next edge; taps still in flight are dropped
  assign osc_core_run_o   = osc[`TCSR_OSC_CORE];
  assign osc_periph_run_o = osc[`TCSR_OSC_PERIPH];
  // Counters 0 and 1 are core, 2 and 3 peripheral
  assign osc_en = {{2{osc[`TCSR_OSC_PERIPH]}}, {2{osc[`TCSR_OSC_CORE]}}};

  // Oscillator taps are asynchronous; two flops, then an edge stage
  // The third flop only feeds edge detection, never other logic
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      tick_s1 <= 4'h0;
      tick_s2 <= 4'h0;
      tick_s3 <= 4'h0;
    end else begin
      tick_s1 <= osc_tick_i;
      tick_s2 <= tick_s1;
      tick_s3 <= tick_s2;
    end
  end

  // Counters keep their value through reset; sampling aliases the
  // oscillator rate, which is fine for a random source
  // Either tick direction counts, so each period adds two
  always_ff @(posedge clock_i) begin
    for (int i = 0; i < 4; i++) begin
      if (osc_en[i] && (tick_s2[i] != tick_s3[i])) begin
        osc_cnt[i] <= osc_cnt[i] + CNT_W'(1);
      end
    end
  end

endmodule

/* design/tcsr_defines.svh */
// Register numbers, field positions, masks and reset values
`ifndef TCSR_DEFINES_SVH
`define TCSR_DEFINES_SVH

// Register numbers within the status space
`define TCSR_REG_FEAT     8'h02
`define TCSR_REG_BOOT     8'h03
`define TCSR_REG_SEC      8'h05
`define TCSR_REG_OSC      8'h06
`define TCSR_REG_CNT0     8'h07
`define TCSR_REG_CNT3     8'h0A
`define TCSR_PS_LOW       8'h0B

// Writable bits and reset values
`define TCSR_FEAT_MASK    32'h03FF_FF36
`define TCSR_FEAT_RST     32'h0000_0000
`define TCSR_SEC_MASK     32'h8000_5FB1
`define TCSR_SEC_RST      32'h0000_0000
`define TCSR_OSC_MASK     32'h0000_0003
`define TCSR_OSC_RST      32'h0000_0000

// Feature control fields
`define TCSR_FEAT_DLY_MSB 25
`define TCSR_FEAT_DLY_LSB 18
`define TCSR_FEAT_DIV_MSB 17
`define TCSR_FEAT_DIV_LSB 9
`define TCSR_FEAT_RGMII   8
`define TCSR_FEAT_DYN     5
`define TCSR_FEAT_DIVEN   4
`define TCSR_FEAT_UTMI    2
`define TCSR_FEAT_ULPI    1

// Boot status fields
`define TCSR_BOOT_PROC_LSB 16
`define TCSR_BOOT_OVR      8
`define TCSR_BOOT_CORE1    5
`define TCSR_BOOT_NOPOLL   4
`define TCSR_BOOT_RAM      3
`define TCSR_BOOT_JTAG     2
`define TCSR_BOOT_PLL_LSB  0

// Security fields
`define TCSR_SEC_LOCK     31
`define TCSR_SEC_GDBG     14
`define TCSR_SEC_OTPALL   12
`define TCSR_SEC_SECT_MSB 11
`define TCSR_SEC_SECT_LSB 8
`define TCSR_SEC_RED      7
`define TCSR_SEC_OTPBOOT  5
`define TCSR_SEC_CFGJTAG  4
`define TCSR_SEC_TAP      0

// Oscillator run control fields
`define TCSR_OSC_CORE     1
`define TCSR_OSC_PERIPH   0

`endif

/* design/tcsr_pkg.sv */
// Types shared by the tile control and status registers
package tcsr_pkg;

  // Status-space request from the processor
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] resource;
    logic [31:0] wdata;
  } tcsr_ps_req_type;

  // Answer to a status-space request
  typedef struct packed {
    logic        ack;
    logic        err;
    logic [31:0] rdata;
  } tcsr_ps_rsp_type;

  // Boot straps and boot flags
  typedef struct packed {
    logic [7:0] proc_num;
    logic       mode_ovr;
    logic       core1_off;
    logic       no_otp_poll;
    logic       boot_ram;
    logic       boot_jtag;
    logic [1:0] pll_mode;
  } tcsr_boot_type;

  // One transmit beat of the reduced-pin link
  typedef struct packed {
    logic       ctl;
    logic [3:0] txd;
  } tcsr_tx_type;

endpackage

/* testbench/tcsr_regs_assertions.sv */
// Port checker for the tile control and status registers
`timescale 1ns/1ps
`include "tcsr_defines.svh"
module tcsr_regs_chk
  import tcsr_pkg::*;
(
  input wire logic            clock_i,
  input wire logic            resetn_i,
  input wire tcsr_ps_req_type ps_req_i,
  input wire tcsr_ps_rsp_type ps_rsp_o,
  input wire logic            otp_sec_valid_i,
  input wire logic [31:0]     otp_sec_word_i,
  input wire tcsr_tx_type     tx_beat_o,
  input wire logic            tx_clk_o,
  input wire logic            rgmii_port_en_o,
  input wire logic            usb_utmi_sel_o,
  input wire logic            ulpi_assist_en_o,
  input wire logic            jtag_tap_block_o,
  input wire logic            boot_from_otp_o,
  input wire logic            otp_lock_all_o,
  input wire logic [3:0]      otp_sector_lock_o,
  input wire logic            osc_core_run_o,
  input wire logic            osc_periph_run_o
);
  localparam logic [15:0] feat_id = {`TCSR_REG_FEAT, `TCSR_PS_LOW};
  localparam logic [15:0] boot_id = {`TCSR_REG_BOOT, `TCSR_PS_LOW};
  localparam logic [15:0] sec_id  = {`TCSR_REG_SEC, `TCSR_PS_LOW};
  localparam logic [15:0] osc_id  = {`TCSR_REG_OSC, `TCSR_PS_LOW};
  logic loaded;
  logic wr;

  // Only the first OTP word after reset counts; later pulses are ignored
  always_ff @(posedge clock_i) begin
    if (!resetn_i) loaded <= 1'h0;
    else if (otp_sec_valid_i) loaded <= 1'h1;
  end

  // A first OTP load beats a write in the same cycle
  assign wr = ps_req_i.wr && !(otp_sec_valid_i && !loaded);

  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  a_ack_after_req: assert property (
    (ps_req_i.rd || ps_req_i.wr) |=> ps_rsp_o.ack)
    else $error("request without ack");
  a_no_idle_ack: assert property (
    !(ps_req_i.rd || ps_req_i.wr) |=> !ps_rsp_o.ack)
    else $error("ack without request");
  a_otp_first_load: assert property (
    otp_sec_valid_i && !loaded |=>
      jtag_tap_block_o == $past(otp_sec_word_i[0]) &&
      boot_from_otp_o == $past(otp_sec_word_i[5]))
    else $error("otp word not loaded");
  a_sec_write_lands: assert property (
    wr && ps_req_i.resource == sec_id |=> ps_rsp_o.err ||
      jtag_tap_block_o == $past(ps_req_i.wdata[0]))
    else $error("security write lost");
  a_boot_write_err: assert property (
    ps_req_i.wr && ps_req_i.resource == boot_id |=> ps_rsp_o.err)
    else $error("boot status write accepted");
  a_feat_write_lands: assert property (
    ps_req_i.wr && ps_req_i.resource == feat_id |=>
      usb_utmi_sel_o == $past(ps_req_i.wdata[2]) &&
      ulpi_assist_en_o == $past(ps_req_i.wdata[1]) &&
      rgmii_port_en_o == $past(ps_req_i.wdata[8]))
    else $error("feature write lost");
  a_feat_rsvd_zero: assert property (
    ps_req_i.rd && ps_req_i.resource == feat_id |=>
      (ps_rsp_o.rdata & ~`TCSR_FEAT_MASK) == 32'h0)
    else $error("reserved feature bits set");
  a_sector_fold: assert property (
    otp_lock_all_o |-> otp_sector_lock_o == 4'hF)
    else $error("all-sector lock not folded");
  a_port_off_quiet: assert property (
    !rgmii_port_en_o ##1 !rgmii_port_en_o |-> !tx_clk_o && tx_beat_o == '0)
    else $error("transmit active while disabled");
  a_osc_write_lands: assert property (
    ps_req_i.wr && ps_req_i.resource == osc_id |=>
      osc_core_run_o == $past(ps_req_i.wdata[1]) &&
      osc_periph_run_o == $past(ps_req_i.wdata[0]))
    else $error("oscillator enables wrong");
endmodule

bind tcsr_regs tcsr_regs_chk tcsr_regs_chk_i (
  .clock_i           (clock_i),
  .resetn_i          (resetn_i),
  .ps_req_i          (ps_req_i),
  .ps_rsp_o          (ps_rsp_o),
  .otp_sec_valid_i   (otp_sec_valid_i),
  .otp_sec_word_i    (otp_sec_word_i),
  .tx_beat_o         (tx_beat_o),
  .tx_clk_o          (tx_clk_o),
  .rgmii_port_en_o   (rgmii_port_en_o),
  .usb_utmi_sel_o    (usb_utmi_sel_o),
  .ulpi_assist_en_o  (ulpi_assist_en_o),
  .jtag_tap_block_o  (jtag_tap_block_o),
  .boot_from_otp_o   (boot_from_otp_o),
  .otp_lock_all_o    (otp_lock_all_o),
  .otp_sector_lock_o (otp_sector_lock_o),
  .osc_core_run_o    (osc_core_run_o),
  .osc_periph_run_o  (osc_periph_run_o)
);

/* testbench/tb_top.sv */
// Self-checking bench for the tile control and status registers
`timescale 1ns/1ps
`include "tcsr_defines.svh"
module tb_top
  import tcsr_pkg::*;
;
  logic            clock_i = 1'h0;
  logic            resetn_i = 1'h0;
  tcsr_ps_req_type ps_req_i = '0;
  tcsr_ps_rsp_type ps_rsp_o;
  tcsr_boot_type   boot_pins_i = {8'hA5, 1'h1, 1'h1, 1'h0, 1'h1, 1'h0, 2'h2};
  logic            otp_sec_valid_i = 1'h0;
  logic [31:0]     otp_sec_word_i = 32'h0;
  logic            all_paused_i = 1'h0;
  tcsr_tx_type     tx_beat_i = '0;
  tcsr_tx_type     tx_beat_o;
  logic [3:0]      osc_tick_i = 4'h0;
  logic [3:0]      otp_sector_lock_o;
  logic            tx_clk_o, rgmii_port_en_o, clk_div_active_o;
  logic            usb_utmi_sel_o, ulpi_assist_en_o, jtag_tap_block_o;
  logic            global_debug_block_o, cfg_jtag_block_o, boot_from_otp_o;
  logic            otp_redundancy_en_o, otp_lock_all_o;
  logic            osc_core_run_o, osc_periph_run_o;
  int              failures = 0;
  int              comparisons = 0;
  wire [9:0]       sec_pins = {global_debug_block_o, otp_lock_all_o,
                               otp_sector_lock_o, otp_redundancy_en_o,
                               boot_from_otp_o, cfg_jtag_block_o,
                               jtag_tap_block_o};

  tcsr_regs tcsr_regs_i (
    .clock_i              (clock_i),
    .resetn_i             (resetn_i),
    .ps_req_i             (ps_req_i),
    .ps_rsp_o             (ps_rsp_o),
    .boot_pins_i          (boot_pins_i),
    .otp_sec_valid_i      (otp_sec_valid_i),
    .otp_sec_word_i       (otp_sec_word_i),
    .all_paused_i         (all_paused_i),
    .tx_beat_i            (tx_beat_i),
    .tx_beat_o            (tx_beat_o),
    .tx_clk_o             (tx_clk_o),
    .rgmii_port_en_o      (rgmii_port_en_o),
    .clk_div_active_o     (clk_div_active_o),
    .usb_utmi_sel_o       (usb_utmi_sel_o),
    .ulpi_assist_en_o     (ulpi_assist_en_o),
    .jtag_tap_block_o     (jtag_tap_block_o),
    .global_debug_block_o (global_debug_block_o),
    .cfg_jtag_block_o     (cfg_jtag_block_o),
    .boot_from_otp_o      (boot_from_otp_o),
    .otp_redundancy_en_o  (otp_redundancy_en_o),
    .otp_lock_all_o       (otp_lock_all_o),
    .otp_sector_lock_o    (otp_sector_lock_o),
    .osc_tick_i           (osc_tick_i),
    .osc_core_run_o       (osc_core_run_o),
    .osc_periph_run_o     (osc_periph_run_o)
  );

  // Free-running 50 MHz core clock
  initial begin
    forever #10 clock_i = ~clock_i;
  end

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One request pulse; the answer is sampled in the cycle after it
  task automatic acc(input logic wr, input logic [7:0] num,
                     input logic [31:0] wd, input logic [31:0] exp,
                     input logic err, input logic [7:0] low = `TCSR_PS_LOW);
    @(negedge clock_i);
    ps_req_i <= '{wr: wr, rd: !wr, resource: {num, low}, wdata: wd};
    @(negedge clock_i);
    ps_req_i <= '0;
    chk("ack", 32'h1, {31'h0, ps_rsp_o.ack});
    chk("err", {31'h0, err}, {31'h0, ps_rsp_o.err});
    chk("rdata", exp, ps_rsp_o.rdata);
  endtask

  task automatic results();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    int highs;
    highs = 0;
    repeat (8) @(negedge clock_i);
    resetn_i <= 1'h1;
    // Reset values and refused accesses
    acc(1'h0, `TCSR_REG_FEAT, 32'h0, 32'h0, 1'h0);
    acc(1'h0, `TCSR_REG_SEC, 32'h0, 32'h0, 1'h0);
    acc(1'h0, `TCSR_REG_OSC, 32'h0, 32'h0, 1'h0);
    acc(1'h0, 8'h04, 32'h0, 32'h0, 1'h1);
    acc(1'h1, `TCSR_REG_FEAT, 32'h10, 32'h0, 1'h1, 8'h0C);
    acc(1'h0, `TCSR_REG_FEAT, 32'h0, 32'h0, 1'h0);
    // Boot straps through the two-flop synchroniser
    acc(1'h0, `TCSR_REG_BOOT, 32'h0, 32'h00A5_012A, 1'h0);
    boot_pins_i <= {8'h5A, 1'h0, 1'h0, 1'h1, 1'h0, 1'h1, 2'h1};
    repeat (3) @(negedge clock_i);
    acc(1'h0, `TCSR_REG_BOOT, 32'h0, 32'h005A_0015, 1'h0);
    acc(1'h1, `TCSR_REG_BOOT, 32'hFFFF_FFFF, 32'h0, 1'h1);
    acc(1'h0, `TCSR_REG_BOOT, 32'h0, 32'h005A_0015, 1'h0);
    // Feature bits, reserved bits masked
    acc(1'h1, `TCSR_REG_FEAT, 32'hFFFF_FFFF, 32'h0, 1'h0);
    acc(1'h0, `TCSR_REG_FEAT, 32'h0, `TCSR_FEAT_MASK, 1'h0);
    chk("usb pins", 32'h3, {30'h0, usb_utmi_sel_o, ulpi_assist_en_o});
    acc(1'h1, `TCSR_REG_FEAT, 32'h2, 32'h0, 1'h0);
    chk("usb pins", 32'h1, {30'h0, usb_utmi_sel_o, ulpi_assist_en_o});
    // Static and dynamic divider
    acc(1'h1, `TCSR_REG_FEAT, 32'h10, 32'h0, 1'h0);
    repeat (2) @(negedge clock_i);
    chk("divider", 32'h1, {31'h0, clk_div_active_o});
    acc(1'h1, `TCSR_REG_FEAT, 32'h30, 32'h0, 1'h0);
    repeat (2) @(negedge clock_i);
    chk("divider", 32'h0, {31'h0, clk_div_active_o});
    all_paused_i <= 1'h1;
    repeat (2) @(negedge clock_i);
    chk("divider", 32'h1, {31'h0, clk_div_active_o});
    // Delay 2, ratio 7 loaded as 6: high 4 of every 7 cycles
    acc(1'h1, `TCSR_REG_FEAT, 32'h0008_0D00, 32'h0, 1'h0);
    for (int m = 0; m < 18; m++) begin
      @(negedge clock_i);
      if (m >= 3) chk("tx beat", (m - 3) & 32'h1F, {27'h0, tx_beat_o});
      if (m >= 4) highs += tx_clk_o;
      tx_beat_i <= tcsr_tx_type'(m[4:0]);
    end
    chk("tx clock highs", 32'h8, highs);
    acc(1'h1, `TCSR_REG_FEAT, 32'h0, 32'h0, 1'h0);
    repeat (2) @(negedge clock_i);
    chk("tx off", 32'h0, {26'h0, tx_clk_o, tx_beat_o});
    // OTP word: first valid cycle taken, second ignored
    otp_sec_valid_i <= 1'h1;
    otp_sec_word_i <= 32'h6000_2A23;
    @(negedge clock_i);
    otp_sec_word_i <= 32'h0;
    @(negedge clock_i);
    otp_sec_valid_i <= 1'h0;
    acc(1'h0, `TCSR_REG_SEC, 32'h0, 32'h0000_0A21, 1'h0);
    chk("security pins", 32'h0A5, {22'h0, sec_pins});
    acc(1'h1, `TCSR_REG_SEC, 32'h0000_5090, 32'h0, 1'h0);
    chk("security pins", 32'h3FA, {22'h0, sec_pins});
    acc(1'h1, `TCSR_REG_SEC, 32'h8000_0000, 32'h0, 1'h0);
    acc(1'h1, `TCSR_REG_SEC, 32'h0000_0001, 32'h0, 1'h1);
    acc(1'h0, `TCSR_REG_SEC, 32'h0, 32'h8000_0000, 1'h0);
    chk("tap block", 32'h0, {31'h0, jtag_tap_block_o});
    // Oscillator enables, each bit on its own
    acc(1'h1, `TCSR_REG_OSC, 32'hFFFF_FFFF, 32'h0, 1'h0);
    acc(1'h0, `TCSR_REG_OSC, 32'h0, 32'h3, 1'h0);
    osc_tick_i <= 4'hF;
    acc(1'h1, `TCSR_REG_OSC, 32'h1, 32'h0, 1'h0);
    chk("osc run", 32'h1, {30'h0, osc_core_run_o, osc_periph_run_o});
    acc(1'h1, `TCSR_REG_OSC, 32'h2, 32'h0, 1'h0);
    chk("osc run", 32'h2, {30'h0, osc_core_run_o, osc_periph_run_o});
    // Only lane 0 toggles while the core pair runs; then stop and settle
    osc_tick_i <= 4'hE;
    repeat (3) @(negedge clock_i);
    acc(1'h1, `TCSR_REG_OSC, 32'h0, 32'h0, 1'h0);
    repeat (10) @(negedge clock_i);
    acc(1'h0, `TCSR_REG_CNT0, 32'h0, 32'h1, 1'h0);
    acc(1'h0, 8'h08, 32'h0, 32'h0, 1'h0);
    acc(1'h0, 8'h09, 32'h0, 32'h1, 1'h0);
    acc(1'h1, `TCSR_REG_CNT3, 32'h5, 32'h0, 1'h1);
    acc(1'h0, `TCSR_REG_CNT3, 32'h0, 32'h1, 1'h0);
    results();
  end
endmodule
